// ---- tb/periph_model.sv ----
// peripheral sitting behind one strobe pin, counts accepted transfers
// assumes the bench routes the selected pin level and its polarity in
`timescale 1ns/10ps

module periph_model (
  input  wire logic clock_i,
  input  wire logic cs_i,
  input  wire logic active_high_i,
  input  wire logic ext_rd_n_i,
  input  wire logic ext_wr_n_i,
  output int        xfer_cnt_o
);
  // **********
  // transfer counter
  // **********
  // a late or short strobe shows up as a missing count
  initial xfer_cnt_o = 0;

  always @(posedge clock_i) begin
    if ((cs_i === active_high_i) && !(ext_rd_n_i && ext_wr_n_i)) begin
      xfer_cnt_o <= xfer_cnt_o + 1;
    end
  end
endmodule // periph_model

// ---- tb/testbench.sv ----
// self-checking bench for the strobe port and extra interrupts
// assumes pins are pulled up whenever nobody drives them
`timescale 1ns/10ps

`define CHECK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
  end \
end

module testbench;
  typedef struct {
    logic [1:0]  pin;
    logic [1:0]  mode;
    logic [1:0]  cmp;
    logic        pol;
    logic [15:0] base;
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic        act;
  } row_t;

  // **********
  // signals
  // **********
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  sfr_addr_i = 8'h00;
  logic [7:0]  sfr_wdata_i = 8'h00;
  logic        sfr_wr_i = 1'b0;
  logic        sfr_rd_i = 1'b0;
  logic [7:0]  sfr_rdata_o;
  logic [7:0]  bit_addr_i = 8'h00;
  logic        bit_wr_i = 1'b0;
  logic        bit_val_i = 1'b0;
  logic [15:0] ext_addr_i = 16'h0000;
  logic        ext_rd_n_i = 1'b1;
  logic        ext_wr_n_i = 1'b1;
  logic [3:0]  tb_pin = 4'hf;
  logic [3:0]  pin_w;
  logic [3:0]  pin_o;
  logic [3:0]  pin_oe_o;
  logic        pullup_o;
  logic [5:0]  std_req_i = 6'h00;
  logic [5:0]  std_high_i = 6'h00;
  logic        irq_ack_i = 1'b0;
  logic        irq_req_o;
  logic        irq_high_o;
  logic [7:0]  irq_vector_o;
  logic [1:0]  cur_pin = 2'd0;
  logic        cur_pol = 1'b0;
  int          xfer_cnt;
  int          error_cnt = 0;
  int          tests_run = 0;
  logic [7:0]  std_vec [6] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b};
  row_t        rows [11] = '{
    '{2'd0, 2'd1, 2'd0, 1'b0, 16'h1234, 16'h1234, 1'b1, 1'b0, 1'b1},
    '{2'd0, 2'd1, 2'd0, 1'b0, 16'h1234, 16'h1234, 1'b0, 1'b1, 1'b0},
    '{2'd1, 2'd2, 2'd1, 1'b1, 16'h1234, 16'h1235, 1'b0, 1'b1, 1'b1},
    '{2'd1, 2'd2, 2'd1, 1'b1, 16'h1234, 16'h1236, 1'b0, 1'b1, 1'b0},
    '{2'd2, 2'd3, 2'd2, 1'b0, 16'h1234, 16'h1237, 1'b1, 1'b0, 1'b1},
    '{2'd2, 2'd3, 2'd2, 1'b1, 16'h1234, 16'h1237, 1'b0, 1'b1, 1'b1},
    '{2'd3, 2'd3, 2'd3, 1'b0, 16'h12aa, 16'h12ff, 1'b1, 1'b0, 1'b1},
    '{2'd3, 2'd3, 2'd3, 1'b0, 16'h12aa, 16'h13aa, 1'b1, 1'b0, 1'b0},
    '{2'd3, 2'd2, 2'd0, 1'b1, 16'h1234, 16'h1234, 1'b1, 1'b0, 1'b0},
    '{2'd0, 2'd1, 2'd0, 1'b1, 16'h1234, 16'h1235, 1'b1, 1'b0, 1'b0},
    '{2'd2, 2'd0, 2'd0, 1'b0, 16'h1234, 16'h1234, 1'b1, 1'b0, 1'b0}};

  // released pins float up to the pull-up level
  assign pin_w = (pin_oe_o & pin_o) | (~pin_oe_o & tb_pin);

  always #5 clock_i = ~clock_i;

  strobe_port dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .bit_addr_i(bit_addr_i),
    .bit_wr_i(bit_wr_i), .bit_val_i(bit_val_i), .ext_addr_i(ext_addr_i),
    .ext_rd_n_i(ext_rd_n_i), .ext_wr_n_i(ext_wr_n_i), .pin_i(pin_w),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .port_zero_pullup_en_o(pullup_o),
    .std_req_i(std_req_i), .std_high_i(std_high_i),
    .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o),
    .irq_high_o(irq_high_o), .irq_vector_o(irq_vector_o));

  periph_model periph_u (
    .clock_i(clock_i), .cs_i(pin_w[cur_pin]), .active_high_i(cur_pol),
    .ext_rd_n_i(ext_rd_n_i), .ext_wr_n_i(ext_wr_n_i),
    .xfer_cnt_o(xfer_cnt));

  // **********
  // tasks
  // **********
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clock_i);
    sfr_wr_i = 1'b0;
  endtask

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clock_i);
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
  endtask

  task automatic bit_write(input logic [7:0] a, input logic v);
    @(negedge clock_i);
    bit_addr_i = a;
    bit_val_i = v;
    bit_wr_i = 1'b1;
    @(negedge clock_i);
    bit_wr_i = 1'b0;
  endtask

  task automatic summarize;
    $display("tests run %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // bounded wait, a hang ends the run
  task automatic wait_req(input logic exp);
    int n;
    n = 0;
    while (irq_req_o !== exp && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    if (irq_req_o !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t interrupt request wait ran out", $time);
      summarize();
    end
  endtask

  // **********
  // main sequence
  // **********
  initial begin
    logic [7:0]  rd;
    logic [15:0] ctrl;
    logic [7:0]  pol;
    row_t        r;
    int          pn;
    int          cnt0;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    `CHECK(pin_o, 4'hf)
    `CHECK(pin_oe_o, 4'h0)
    for (int p = 0; p < 4; p++) begin
      sfr_read(strobe_port_pkg::ADDR_BASE_LOW[p], rd);
      `CHECK(rd, 8'h00)
      sfr_write(strobe_port_pkg::ADDR_BASE_HIGH[p], 8'h5a ^ 8'(p));
      sfr_read(strobe_port_pkg::ADDR_BASE_HIGH[p], rd);
      `CHECK(rd, 8'h5a ^ 8'(p))
    end
    sfr_read(strobe_port_pkg::ADDR_STROBE_PORT_DATA, rd);
    `CHECK(rd, 8'hff)
    sfr_read(strobe_port_pkg::ADDR_EXTRA_IRQ_CONTROL, rd);
    `CHECK(rd, 8'h00)
    sfr_write(strobe_port_pkg::ADDR_STROBE_POLARITY, 8'hff);
    sfr_read(strobe_port_pkg::ADDR_STROBE_POLARITY, rd);
    `CHECK(rd, 8'hf0)
    sfr_write(8'h87, 8'h55);
    sfr_read(8'h87, rd);
    `CHECK(rd, 8'h00)
    $display("test registers done");

    `CHECK(pullup_o, 1'b0)
    sfr_write(strobe_port_pkg::ADDR_PORT_ZERO_OPTIONS, 8'h01);
    @(negedge clock_i);
    `CHECK(pullup_o, 1'b1)
    sfr_write(strobe_port_pkg::ADDR_PORT_ZERO_OPTIONS, 8'h00);
    @(negedge clock_i);
    `CHECK(pullup_o, 1'b0)
    sfr_write(strobe_port_pkg::ADDR_STROBE_PORT_DATA, 8'hf5);
    repeat (4) @(negedge clock_i);
    `CHECK(pin_o, 4'h5)
    `CHECK(pin_oe_o, 4'ha)
    sfr_read(strobe_port_pkg::ADDR_STROBE_PORT_DATA, rd);
    `CHECK(rd, 8'hf5)
    sfr_write(strobe_port_pkg::ADDR_STROBE_PORT_DATA, 8'hff);
    $display("test gpio done");

    foreach (rows[i]) begin
      r = rows[i];
      pn = int'(r.pin);
      ctrl = 16'h0000;
      ctrl[pn*4 +: 4] = {r.mode, r.cmp};
      pol = 8'h00;
      pol[4 + pn] = r.pol;
      sfr_write(strobe_port_pkg::ADDR_BASE_LOW[pn], r.base[7:0]);
      sfr_write(strobe_port_pkg::ADDR_BASE_HIGH[pn], r.base[15:8]);
      sfr_write(strobe_port_pkg::ADDR_STROBE_CTRL_LOW, ctrl[7:0]);
      sfr_write(strobe_port_pkg::ADDR_STROBE_CTRL_HIGH, ctrl[15:8]);
      sfr_write(strobe_port_pkg::ADDR_STROBE_POLARITY, pol);
      cur_pin = r.pin;
      cur_pol = r.pol;
      cnt0 = xfer_cnt;
      @(negedge clock_i);
      ext_addr_i = r.addr;
      ext_rd_n_i = !r.rd;
      ext_wr_n_i = !r.wr;
      @(negedge clock_i);
      `CHECK(pin_o[pn], ~(r.act ^ r.pol))
      @(negedge clock_i);
      ext_rd_n_i = 1'b1;
      ext_wr_n_i = 1'b1;
      @(negedge clock_i);
      `CHECK(pin_o[pn], ~r.pol)
      `CHECK(xfer_cnt, cnt0 + int'(r.act))
    end
    sfr_write(strobe_port_pkg::ADDR_STROBE_CTRL_LOW, 8'h00);
    sfr_write(strobe_port_pkg::ADDR_STROBE_CTRL_HIGH, 8'h00);
    $display("test strobes done");

    // edge-mode interrupt two on pin 3, high priority
    sfr_write(strobe_port_pkg::ADDR_EXTRA_IRQ_CONTROL, 8'h01);
    bit_write(8'hc2, 1'b1);
    bit_write(8'hc3, 1'b1);
    sfr_read(strobe_port_pkg::ADDR_EXTRA_IRQ_CONTROL, rd);
    `CHECK(rd, 8'h0d)
    tb_pin[3] = 1'b0;
    wait_req(1'b1);
    `CHECK(irq_vector_o, 8'h33)
    `CHECK(irq_high_o, 1'b1)
    sfr_read(strobe_port_pkg::ADDR_EXTRA_IRQ_CONTROL, rd);
    `CHECK(rd, 8'h0f)
    irq_ack_i = 1'b1;
    @(negedge clock_i);
    irq_ack_i = 1'b0;
    wait_req(1'b0);
    sfr_read(strobe_port_pkg::ADDR_EXTRA_IRQ_CONTROL, rd);
    `CHECK(rd, 8'h0d)
    tb_pin[3] = 1'b1;
    // level-mode interrupt three on pin 2, beats a low-priority source
    bit_write(8'hc6, 1'b1);
    bit_write(8'hc7, 1'b1);
    std_req_i = 6'h01;
    tb_pin[2] = 1'b0;
    repeat (6) @(negedge clock_i);
    `CHECK(irq_vector_o, 8'h3b)
    `CHECK(irq_high_o, 1'b1)
    tb_pin[2] = 1'b1;
    repeat (6) @(negedge clock_i);
    `CHECK(irq_vector_o, 8'h03)
    for (int i = 0; i < 6; i++) begin
      std_req_i = 6'h3f << i;
      repeat (2) @(negedge clock_i);
      `CHECK(irq_vector_o, std_vec[i])
    end
    std_req_i = 6'h3f;
    std_high_i = 6'h20;
    repeat (2) @(negedge clock_i);
    `CHECK(irq_vector_o, 8'h2b)
    std_req_i = 6'h00;
    std_high_i = 6'h00;
    wait_req(1'b0);
    $display("test interrupts done");

    // second reset in mid-run with data driven low
    sfr_write(strobe_port_pkg::ADDR_STROBE_PORT_DATA, 8'h00);
    rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    `CHECK(pin_o, 4'hf)
    `CHECK(pin_oe_o, 4'h0)
    `CHECK(irq_req_o, 1'b0)
    $display("test second reset done");
    summarize();
  end
endmodule // testbench

// ---- verilog/strobe_port.sv ----
// programmable strobe port, port-zero option and extra interrupts
// assumes core bus strobes and external bus signals on clock_i;
// only the port pins come from outside and are synchronised
//
// Operation
// R01: eight-bit port data register at D8H, each pin set up alone
// R02: mode 0 is plain pulled-up I/O; pins 3 and 2 feed interrupts
// R03: mode 1 pin follows read strobe inside its address range
// R04: mode 2 pin follows write strobe inside its address range
// R05: mode 3 pin follows read or write strobe inside its range
// R06: each strobe pin has a 16-bit base in high and low bytes
// R07: two control registers pick modes, pins 3-2 and pins 1-0
// R08: port zero open drain unless bit 0 of 86H sets pull-ups
// R09: two extra interrupts, control register bit-addressable at C0H
// R10: bit set at C2H sets interrupt two enable, bit 2
// R11: interrupt three uses bit 7 for priority, bit 6 enable
// R12: interrupt two uses bit 3 for priority, bit 2 enable
// R13: edge mode pending flag set on detect, cleared on service
// R14: trigger bit set means falling edge, clear means low level
// R15: vectors 03H 0BH 13H 1BH 23H 2BH 33H 3BH
// R16: within a level, poll external 0 first, external 3 last
// R17: compare length 00 all, 01 A15-1, 10 A15-2, 11 A15-8
// R18: strobes active low unless their polarity bit is set
// R19: port data register resets to FFH
// R20: strobe stays inactive outside a matching access phase
// R21: peripheral transfers only while its strobe is asserted
`timescale 1ns/10ps

module strobe_port (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  output logic      [7:0]  sfr_rdata_o,
  input  wire logic [7:0]  bit_addr_i,
  input  wire logic        bit_wr_i,
  input  wire logic        bit_val_i,
  input  wire logic [15:0] ext_addr_i,
  input  wire logic        ext_rd_n_i,
  input  wire logic        ext_wr_n_i,
  input  wire logic [3:0]  pin_i,
  output logic      [3:0]  pin_o,
  output logic      [3:0]  pin_oe_o,
  output logic             port_zero_pullup_en_o,
  input  wire logic [5:0]  std_req_i,
  input  wire logic [5:0]  std_high_i,
  input  wire logic        irq_ack_i,
  output logic             irq_req_o,
  output logic             irq_high_o,
  output logic      [7:0]  irq_vector_o
);

  // ****************************************
  // state
  // ****************************************
  logic [7:0]  data_r;
  logic [7:0]  data_nxt;
  logic [7:0]  por_r;
  logic [7:0]  extra_irq_control_r;
  logic [7:0]  extra_irq_control_nxt;
  logic [7:0]  ctrl_low_r;
  logic [7:0]  ctrl_high_r;
  logic [7:0]  polarity_r;
  logic [7:0]  base_low_r  [4];
  logic [7:0]  base_high_r [4];
  logic [3:0]  pin_meta_r;
  logic [3:0]  pin_sync_r;
  logic [3:0]  pin_prev_r;
  logic [2:0]  irq_idx_r;
  logic [15:0] ctrl_all;
  logic [3:0]  strobe_on;
  logic [7:0]  src_req;
  logic [7:0]  src_high;
  logic        sel_found;
  logic        sel_high;
  logic [2:0]  sel_idx;

  assign ctrl_all = {ctrl_high_r, ctrl_low_r}; // R07

  // ****************************************
  // pin synchroniser
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pin_meta_r <= 4'hf;
      pin_sync_r <= 4'hf;
      pin_prev_r <= 4'hf;
    end else begin
      pin_meta_r <= pin_i;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  // ****************************************
  // plain registers
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      por_r       <= strobe_port_pkg::RESET_ZERO;
      ctrl_low_r  <= strobe_port_pkg::RESET_ZERO;
      ctrl_high_r <= strobe_port_pkg::RESET_ZERO;
      polarity_r  <= strobe_port_pkg::RESET_ZERO;
      for (int i = 0; i < strobe_port_pkg::STROBE_PINS; i++) begin
        base_low_r[i]  <= strobe_port_pkg::RESET_ZERO;
        base_high_r[i] <= strobe_port_pkg::RESET_ZERO;
      end
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == strobe_port_pkg::ADDR_PORT_ZERO_OPTIONS)
        por_r <= sfr_wdata_i; // R08
      if (sfr_addr_i == strobe_port_pkg::ADDR_STROBE_CTRL_LOW)
        ctrl_low_r <= sfr_wdata_i; // R07
      if (sfr_addr_i == strobe_port_pkg::ADDR_STROBE_CTRL_HIGH)
        ctrl_high_r <= sfr_wdata_i; // R07
      if (sfr_addr_i == strobe_port_pkg::ADDR_STROBE_POLARITY)
        polarity_r <= {sfr_wdata_i[7:4], 4'h0}; // R18
      for (int i = 0; i < strobe_port_pkg::STROBE_PINS; i++) begin
        if (sfr_addr_i == strobe_port_pkg::ADDR_BASE_LOW[i])
          base_low_r[i] <= sfr_wdata_i; // R06
        if (sfr_addr_i == strobe_port_pkg::ADDR_BASE_HIGH[i])
          base_high_r[i] <= sfr_wdata_i; // R06
      end
    end
  end

  // ****************************************
  // port data, byte and bit writes
  // ****************************************
  always_comb begin
    data_nxt = data_r;
    if (sfr_wr_i && sfr_addr_i == strobe_port_pkg::ADDR_STROBE_PORT_DATA)
      data_nxt = sfr_wdata_i; // R01
    if (bit_wr_i &&
        bit_addr_i[7:3] == strobe_port_pkg::ADDR_STROBE_PORT_DATA[7:3])
      data_nxt[bit_addr_i[2:0]] = bit_val_i; // R01
  end

  always_ff @(posedge clock_i) begin
    if (rst_i)
      data_r <= strobe_port_pkg::RESET_PORT_DATA; // R19
    else
      data_r <= data_nxt;
  end

  // ****************************************
  // extra interrupt control
  // ****************************************
  // hardware detection is applied last so a set beats any clear
  always_comb begin
    extra_irq_control_nxt = extra_irq_control_r;
    if (sfr_wr_i && sfr_addr_i == strobe_port_pkg::ADDR_EXTRA_IRQ_CONTROL)
      extra_irq_control_nxt = sfr_wdata_i; // R09
    if (bit_wr_i &&
        bit_addr_i[7:3] == strobe_port_pkg::ADDR_EXTRA_IRQ_CONTROL[7:3])
      extra_irq_control_nxt[bit_addr_i[2:0]] = bit_val_i; // R10
    for (int j = 0; j < strobe_port_pkg::EXTRA_IRQS; j++) begin
      if (extra_irq_control_r[j*strobe_port_pkg::IRQ_FIELD_W +
                  strobe_port_pkg::IRQ_EDGE_BIT]) begin
        if (irq_ack_i &&
            irq_idx_r == 3'(strobe_port_pkg::STD_SOURCES + j))
          extra_irq_control_nxt[j*strobe_port_pkg::IRQ_FIELD_W +
                    strobe_port_pkg::IRQ_PEND_BIT] = 1'b0; // R13
        if (pin_prev_r[strobe_port_pkg::IRQ_PIN[j]] &&
            !pin_sync_r[strobe_port_pkg::IRQ_PIN[j]])
          extra_irq_control_nxt[j*strobe_port_pkg::IRQ_FIELD_W +
                    strobe_port_pkg::IRQ_PEND_BIT] = 1'b1; // R14
      end else begin
        // level mode: flag simply tracks the pin
        extra_irq_control_nxt[j*strobe_port_pkg::IRQ_FIELD_W +
                  strobe_port_pkg::IRQ_PEND_BIT] =
          !pin_sync_r[strobe_port_pkg::IRQ_PIN[j]]; // R14
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i)
      extra_irq_control_r <= strobe_port_pkg::RESET_ZERO;
    else
      extra_irq_control_r <= extra_irq_control_nxt; // R09
  end

  // ****************************************
  // strobe decode, one slice per pin
  // ****************************************
  for (genvar g = 0; g < strobe_port_pkg::STROBE_PINS; g++) begin : g_pin
    logic [3:0]  field;
    logic [15:0] mask;
    logic        hit;
    assign field = ctrl_all[g*strobe_port_pkg::CTRL_FIELD_W +: 4];
    assign mask  = strobe_port_pkg::CMP_MASK[field[1:0]]; // R17
    assign hit   = ((ext_addr_i ^ {base_high_r[g], base_low_r[g]})
                   & mask) == 16'h0000; // R06
    always_comb begin
      unique case (strobe_port_pkg::pin_mode_t'(field[3:2]))
        strobe_port_pkg::MODE_GPIO:  strobe_on[g] = 1'b0;
        strobe_port_pkg::MODE_READ:  strobe_on[g] = hit && !ext_rd_n_i; // R03
        strobe_port_pkg::MODE_WRITE: strobe_on[g] = hit && !ext_wr_n_i; // R04
        strobe_port_pkg::MODE_RDWR:
          strobe_on[g] = hit && (!ext_rd_n_i || !ext_wr_n_i); // R05
      endcase
    end

    // one cycle of latency keeps every pin driven from a flop
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        pin_o[g]    <= 1'b1;
        pin_oe_o[g] <= 1'b0;
      end else if (field[3:2] == strobe_port_pkg::MODE_GPIO) begin
        pin_o[g]    <= data_r[g]; // R02
        pin_oe_o[g] <= !data_r[g]; // R02
      end else begin
        pin_o[g]    <= polarity_r[strobe_port_pkg::POLARITY_LSB + g]
                       ? strobe_on[g] : !strobe_on[g]; // R18 R20
        pin_oe_o[g] <= 1'b1;
      end
    end
  end

  // ****************************************
  // interrupt selection
  // ****************************************
  assign src_req = {
    extra_irq_control_r[strobe_port_pkg::IRQ_FIELD_W + strobe_port_pkg::IRQ_EN_BIT] &&
      extra_irq_control_r[strobe_port_pkg::IRQ_FIELD_W + strobe_port_pkg::IRQ_PEND_BIT],
    extra_irq_control_r[strobe_port_pkg::IRQ_EN_BIT] &&
      extra_irq_control_r[strobe_port_pkg::IRQ_PEND_BIT],
    std_req_i}; // R11 R12
  assign src_high = {extra_irq_control_r[7],
                     extra_irq_control_r[strobe_port_pkg::IRQ_PRIO_BIT],
                     std_high_i}; // R11 R12

  // later passes overwrite: high level wins, lowest index wins
  always_comb begin
    sel_found = 1'b0;
    sel_high  = 1'b0;
    sel_idx   = 3'h0;
    for (int i = strobe_port_pkg::SOURCES - 1; i >= 0; i--) begin
      if (src_req[i] && !src_high[i]) begin
        sel_found = 1'b1;
        sel_idx   = 3'(i); // R16
      end
    end
    for (int i = strobe_port_pkg::SOURCES - 1; i >= 0; i--) begin
      if (src_req[i] && src_high[i]) begin
        sel_found = 1'b1;
        sel_high  = 1'b1;
        sel_idx   = 3'(i); // R16
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_req_o    <= 1'b0;
      irq_high_o   <= 1'b0;
      irq_idx_r    <= 3'h0;
      irq_vector_o <= strobe_port_pkg::VECTOR[0];
    end else begin
      irq_req_o    <= sel_found && !irq_ack_i;
      irq_high_o   <= sel_high;
      irq_idx_r    <= sel_idx;
      irq_vector_o <= strobe_port_pkg::VECTOR[sel_idx]; // R15
    end
  end

  // ****************************************
  // read-back and port zero option
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sfr_rdata_o           <= 8'h00;
      port_zero_pullup_en_o <= 1'b0;
    end else begin
      port_zero_pullup_en_o <= por_r[strobe_port_pkg::PULLUP_BIT]; // R08
      sfr_rdata_o <= 8'h00;
      if (sfr_rd_i) begin
        unique case (sfr_addr_i)
          strobe_port_pkg::ADDR_STROBE_PORT_DATA:
            sfr_rdata_o <= {data_r[7:4], pin_sync_r};
          strobe_port_pkg::ADDR_PORT_ZERO_OPTIONS:
            sfr_rdata_o <= {7'h00, por_r[strobe_port_pkg::PULLUP_BIT]};
          strobe_port_pkg::ADDR_EXTRA_IRQ_CONTROL: sfr_rdata_o <= extra_irq_control_r;
          strobe_port_pkg::ADDR_STROBE_CTRL_LOW:   sfr_rdata_o <= ctrl_low_r;
          strobe_port_pkg::ADDR_STROBE_CTRL_HIGH:  sfr_rdata_o <= ctrl_high_r;
          strobe_port_pkg::ADDR_STROBE_POLARITY:   sfr_rdata_o <= polarity_r;
          default: begin
            for (int i = 0; i < strobe_port_pkg::STROBE_PINS; i++) begin
              if (sfr_addr_i == strobe_port_pkg::ADDR_BASE_LOW[i])
                sfr_rdata_o <= base_low_r[i];
              if (sfr_addr_i == strobe_port_pkg::ADDR_BASE_HIGH[i])
                sfr_rdata_o <= base_high_r[i];
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking

  property p_data_reset;
    rst_i |=> data_r == 8'hff;
  endproperty
  a_data_reset: assert property (p_data_reset) // R19
    else $error("port data not ff after reset");

  property p_data_write;
    disable iff (rst_i)
    sfr_wr_i && sfr_addr_i == 8'hd8 && !bit_wr_i
      |=> data_r == $past(sfr_wdata_i);
  endproperty
  a_data_write: assert property (p_data_write) // R01
    else $error("port data write lost");

  property p_read_strobe;
    disable iff (rst_i)
    ctrl_low_r[3:0] == 4'b0100 && polarity_r[4] == 1'b0 &&
      !ext_rd_n_i && ext_addr_i == {base_high_r[0], base_low_r[0]}
      |=> pin_o[0] == 1'b0 && pin_oe_o[0];
  endproperty
  a_read_strobe: assert property (p_read_strobe) // R03
    else $error("read strobe not asserted low");

  // pin 1, A0 masked, active high: the case the bench drives
  property p_write_strobe;
    disable iff (rst_i)
    ctrl_low_r[7:4] == 4'b1001 && polarity_r[5] && !ext_wr_n_i &&
      ext_addr_i[15:1] == {base_high_r[1], base_low_r[1][7:1]}
      |=> pin_o[1] == 1'b1;
  endproperty
  a_write_strobe: assert property (p_write_strobe) // R04
    else $error("inverted write strobe not high");

  property p_rdwr_strobe;
    disable iff (rst_i)
    ctrl_high_r[7:4] == 4'b1111 && polarity_r[7] == 1'b0 &&
      (!ext_rd_n_i || !ext_wr_n_i) && ext_addr_i[15:8] == base_high_r[3]
      |=> pin_o[3] == 1'b0;
  endproperty
  a_rdwr_strobe: assert property (p_rdwr_strobe) // R05
    else $error("combined strobe missing");

  property p_idle_strobe;
    disable iff (rst_i)
    ctrl_low_r[3:2] != 2'b00 && ext_rd_n_i && ext_wr_n_i
      |=> pin_o[0] == !$past(polarity_r[4]);
  endproperty
  a_idle_strobe: assert property (p_idle_strobe) // R20
    else $error("strobe active outside access");

  property p_edge_pending;
    disable iff (rst_i)
    extra_irq_control_r[0] && pin_prev_r[3] && !pin_sync_r[3] |=> extra_irq_control_r[1];
  endproperty
  a_edge_pending: assert property (p_edge_pending) // R14
    else $error("falling edge did not set pending");

  property p_level_pending;
    disable iff (rst_i)
    !extra_irq_control_r[4] |=> extra_irq_control_r[5] == !$past(pin_sync_r[2]);
  endproperty
  a_level_pending: assert property (p_level_pending) // R14
    else $error("level pending does not track pin");

  property p_bit_enable;
    disable iff (rst_i)
    bit_wr_i && bit_val_i && bit_addr_i == 8'hc2 && !sfr_wr_i
      |=> extra_irq_control_r[2];
  endproperty
  a_bit_enable: assert property (p_bit_enable) // R10
    else $error("bit set of enable failed");

  property p_pullup;
    disable iff (rst_i)
    sfr_wr_i && sfr_addr_i == 8'h86
      |=> ##1 port_zero_pullup_en_o == $past(sfr_wdata_i[0], 2);
  endproperty
  a_pullup: assert property (p_pullup) // R08
    else $error("pull-up option not applied");

endmodule // strobe_port

// ---- verilog/strobe_port_pkg.sv ----
// constants for the strobe port and extra interrupt block
// assumes an 8-bit special-register bus and a 16-bit external bus
package strobe_port_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] ADDR_PORT_ZERO_OPTIONS = 8'h86;
  localparam logic [7:0] ADDR_EXTRA_IRQ_CONTROL = 8'hc0;
  localparam logic [7:0] ADDR_STROBE_CTRL_LOW   = 8'hc2;
  localparam logic [7:0] ADDR_STROBE_CTRL_HIGH  = 8'hc3;
  localparam logic [7:0] ADDR_STROBE_POLARITY   = 8'hae;
  localparam logic [7:0] ADDR_STROBE_PORT_DATA  = 8'hd8;
  localparam logic [7:0] ADDR_BASE_LOW [4] = '{8'h84, 8'h94, 8'hac, 8'hb4};
  localparam logic [7:0] ADDR_BASE_HIGH [4] = '{8'h85, 8'h95, 8'had, 8'hb5};

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RESET_PORT_DATA = 8'hff;
  localparam logic [7:0] RESET_ZERO      = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int PULLUP_BIT     = 0;
  localparam int POLARITY_LSB   = 4;
  localparam int CTRL_FIELD_W   = 4;
  localparam int IRQ_FIELD_W    = 4;
  localparam int IRQ_EDGE_BIT   = 0;
  localparam int IRQ_PEND_BIT   = 1;
  localparam int IRQ_EN_BIT     = 2;
  localparam int IRQ_PRIO_BIT   = 3;
  localparam int STROBE_PINS    = 4;
  localparam int EXTRA_IRQS     = 2;
  localparam int STD_SOURCES    = 6;
  localparam int SOURCES        = 8;
  // pin carrying extra interrupt two, then three
  localparam int IRQ_PIN [2] = '{3, 2};

  // ****************************************
  // pin modes and compare lengths
  // ****************************************
  typedef enum logic [1:0] {
    MODE_GPIO   = 2'b00,
    MODE_READ   = 2'b01,
    MODE_WRITE  = 2'b10,
    MODE_RDWR   = 2'b11
  } pin_mode_t;

  localparam logic [15:0] CMP_MASK [4] =
    '{16'hffff, 16'hfffe, 16'hfffc, 16'hff00};

  // ****************************************
  // interrupt vectors in polling order
  // ****************************************
  localparam logic [7:0] VECTOR [8] =
    '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h33, 8'h3b};

endpackage
